//--- scr_regs.sv
// Status flags, program counter low byte, system control registers and
// internal clock enables, reached over an AHB-Lite slave port.
// Assumes one 100 MHz clock, a synchronous active-high reset and a core
// that presents flag updates and system events as one-cycle strobes.
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "scr_map.svh"

module scr_regs (
    // Clock and reset.
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_reset,
    // AHB-Lite slave.
    input  wire logic                    i_hsel,
    input  wire logic [11:0]             i_haddr,
    input  wire logic [1:0]              i_htrans,
    input  wire logic                    i_hwrite,
    input  wire logic [2:0]              i_hsize,
    input  wire logic [31:0]             i_hwdata,
    input  wire logic                    i_hready,
    output logic      [31:0]             o_hrdata,
    output logic                         o_hreadyout,
    output logic                         o_hresp,
    // Core side.
    input  wire scr_pkg::scr_alu_type    i_alu,
    input  wire scr_pkg::scr_sys_ev_type i_sys_ev,
    input  wire logic                    i_wake,
    input  wire logic                    i_slow_users_on,
    input  wire logic [10:0]             i_pc,
    output logic      [10:0]             o_pc_load,
    output logic                         o_pc_load_stb,
    output logic                         o_core_stall,
    // Control outputs.
    output logic                         o_pwm_split_7p1,
    output logic                         o_pwm_pin_sel,
    output logic                         o_pfd_pin_sel,
    output logic      [1:0]              o_ext_edge_sel,
    output logic      [1:0]              o_tb_period_sel,
    output logic      [13:0]             o_tb_period_cycles,
    // Clock enables and sleep state.
    output logic                         o_sys_clk_en,
    output logic                         o_slow_clk_en,
    output logic                         o_sleeping
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int FAST_DIV = `SCR_FAST_DIV;
    localparam int SLOW_DIV = `SCR_SLOW_DIV;

    logic [7:0]                 status_ff;
    logic [7:0]                 ctrl_a_ff;
    logic [7:0]                 ctrl_b_ff;
    logic                       sleep_ff;
    logic                       wr_pend_ff;
    scr_pkg::scr_reg_type       wr_reg_ff;
    scr_pkg::scr_pc_state_type  pc_state_ff;
    logic [3:0]                 fast_cnt_ff;
    logic [13:0]                slow_cnt_ff;
    logic                       slow_run_ff;
    scr_pkg::scr_reg_type       addr_reg;
    logic                       addr_ok;
    logic                       bus_wr;
    logic [7:0]                 wbyte;
    logic [7:0]                 nxt_flags;
    logic [8:0]                 sum9;
    logic [4:0]                 sum5;
    logic [7:0]                 sum7;

    // Maps a byte offset to a register.
    function automatic scr_pkg::scr_reg_type decode(input logic [11:0] a);
        case (a)
            `SCR_OFF_PC_LOW: decode = scr_pkg::SCR_REG_PC;
            `SCR_OFF_STATUS: decode = scr_pkg::SCR_REG_STATUS;
            `SCR_OFF_CTRL_A: decode = scr_pkg::SCR_REG_CTRL_A;
            `SCR_OFF_CTRL_B: decode = scr_pkg::SCR_REG_CTRL_B;
            `SCR_OFF_OSC:    decode = scr_pkg::SCR_REG_OSC;
            default:         decode = scr_pkg::SCR_REG_NONE;
        endcase
    endfunction

    // ****************************************************************
    // Bus address phase
    // ****************************************************************
    // An access is taken when selected, NONSEQ or SEQ, and hready is high.
    always_comb begin
        addr_reg = decode(i_haddr);
        addr_ok  = i_hsel && i_htrans[1] && i_hready;
        bus_wr   = wr_pend_ff;
        wbyte    = i_hwdata[7:0];
    end

    // Writes are captured at the address phase and applied in the data phase.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wr_pend_ff <= 1'b0;
            wr_reg_ff  <= scr_pkg::SCR_REG_NONE;
        end else begin
            wr_pend_ff <= addr_ok && i_hwrite;
            wr_reg_ff  <= addr_ok ? addr_reg : scr_pkg::SCR_REG_NONE;
        end
    end

    // Zero wait state, always OKAY.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    // Read data is registered at the address phase; unmapped reads zero.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_hrdata <= 32'h00000000;
        end else if (addr_ok && !i_hwrite) begin
            case (addr_reg)
                scr_pkg::SCR_REG_PC:     o_hrdata <= {24'h000000, i_pc[7:0]};
                scr_pkg::SCR_REG_STATUS: o_hrdata <= {24'h000000, status_ff};
                scr_pkg::SCR_REG_CTRL_A: o_hrdata <= {24'h000000, ctrl_a_ff};
                scr_pkg::SCR_REG_CTRL_B: o_hrdata <= {24'h000000, ctrl_b_ff};
                scr_pkg::SCR_REG_OSC:    o_hrdata <= {30'h0, slow_run_ff, sleep_ff};
                default:                 o_hrdata <= 32'h00000000;
            endcase
        end else begin
            o_hrdata <= 32'h00000000;
        end
    end

    // ****************************************************************
    // Program counter low byte
    // ****************************************************************
    // A low-byte write keeps the page bits and stalls the core one cycle.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pc_state_ff   <= scr_pkg::SCR_PC_RUN;
            o_pc_load     <= 11'h000;
            o_pc_load_stb <= 1'b0;
            o_core_stall  <= 1'b0;
        end else begin
            o_pc_load_stb <= 1'b0;
            case (pc_state_ff)
                scr_pkg::SCR_PC_RUN: begin
                    o_core_stall <= 1'b0;
                    if (bus_wr && wr_reg_ff == scr_pkg::SCR_REG_PC) begin
                        o_pc_load     <= {i_pc[10:8], wbyte};
                        o_pc_load_stb <= 1'b1;
                        o_core_stall  <= 1'b1;
                        pc_state_ff   <= scr_pkg::SCR_PC_DUMMY;
                    end
                end
                scr_pkg::SCR_PC_DUMMY: begin
                    o_core_stall <= 1'b0;
                    pc_state_ff  <= scr_pkg::SCR_PC_RUN;
                end
                default: pc_state_ff <= scr_pkg::SCR_PC_RUN;
            endcase
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // Arithmetic flag computation from the latest operation.
    always_comb begin
        sum9 = i_alu.is_sub ? ({1'b0, i_alu.opa} + {1'b0, ~i_alu.opb} + 9'h001)
                            : ({1'b0, i_alu.opa} + {1'b0, i_alu.opb});
        sum5 = i_alu.is_sub ? ({1'b0, i_alu.opa[3:0]} + {1'b0, ~i_alu.opb[3:0]} + 5'h01)
                            : ({1'b0, i_alu.opa[3:0]} + {1'b0, i_alu.opb[3:0]});
        sum7 = i_alu.is_sub ? ({1'b0, i_alu.opa[6:0]} + {1'b0, ~i_alu.opb[6:0]} + 8'h01)
                            : ({1'b0, i_alu.opa[6:0]} + {1'b0, i_alu.opb[6:0]});
        nxt_flags = status_ff;
        if (i_alu.valid && i_alu.upd_wrap) begin
            nxt_flags[`SCR_ST_WRAP] = sum7[7] ^ sum9[8];
        end
        if (i_alu.valid && i_alu.upd_null) begin
            nxt_flags[`SCR_ST_NULL] = (i_alu.result == 8'h00);
        end
        if (i_alu.valid && i_alu.upd_half) begin
            nxt_flags[`SCR_ST_HALF] = sum5[4];
        end
        if (i_alu.valid && i_alu.upd_carry) begin
            nxt_flags[`SCR_ST_CARRY] = i_alu.is_rotate ? i_alu.rot_carry : sum9[8];
        end
    end

    // Software writes the arithmetic flags and a core update in the same cycle
    // wins over the write. System flags move only on power-up, watchdog events
    // and sleep, and no call or interrupt pushes this register anywhere.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            status_ff <= 8'h00;
        end else begin
            status_ff[7:6] <= 2'b00;
            if (i_alu.valid) begin
                status_ff[3:0] <= nxt_flags[3:0];
            end else if (bus_wr && wr_reg_ff == scr_pkg::SCR_REG_STATUS) begin
                status_ff[3:0] <= wbyte[3:0] & 4'(`SCR_STATUS_WMASK);
            end
            if (i_sys_ev.wdt_timeout) begin
                status_ff[`SCR_ST_WDT_EXP] <= 1'b1;
            end else if (i_sys_ev.wdt_clear || i_sys_ev.sleep) begin
                status_ff[`SCR_ST_WDT_EXP] <= 1'b0;
            end
            if (i_sys_ev.sleep) begin
                status_ff[`SCR_ST_SLEEP] <= 1'b1;
            end else if (i_sys_ev.wdt_clear) begin
                status_ff[`SCR_ST_SLEEP] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // System control registers
    // ****************************************************************
    // Only implemented bits are stored.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ctrl_a_ff <= `SCR_CTRL_A_RST;
            ctrl_b_ff <= `SCR_CTRL_B_RST;
        end else if (bus_wr && wr_reg_ff == scr_pkg::SCR_REG_CTRL_A) begin
            ctrl_a_ff <= wbyte & `SCR_CTRL_A_MASK;
        end else if (bus_wr && wr_reg_ff == scr_pkg::SCR_REG_CTRL_B) begin
            ctrl_b_ff <= wbyte & `SCR_CTRL_B_MASK;
        end
    end

    // Control fields drive the pin muxes and time-base selector.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_pwm_split_7p1    <= 1'b0;
            o_pwm_pin_sel      <= 1'b0;
            o_pfd_pin_sel      <= 1'b0;
            o_ext_edge_sel     <= 2'b10;
            o_tb_period_sel    <= 2'b00;
            o_tb_period_cycles <= 14'h0400;
        end else begin
            o_pwm_split_7p1    <= ctrl_a_ff[`SCR_CA_SPLIT];
            o_pwm_pin_sel      <= ctrl_a_ff[`SCR_CA_PWM_PIN];
            o_pfd_pin_sel      <= ctrl_a_ff[`SCR_CA_PFD_PIN];
            o_ext_edge_sel     <= ctrl_b_ff[7:6];
            o_tb_period_sel    <= ctrl_b_ff[5:4];
            o_tb_period_cycles <= 14'h0400 << ctrl_b_ff[5:4];
        end
    end

    // ****************************************************************
    // Clock sources
    // ****************************************************************
    // Sleep holds from the sleep instruction to a wake event.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sleep_ff <= 1'b0;
        end else if (i_wake) begin
            sleep_ff <= 1'b0;
        end else if (i_sys_ev.sleep) begin
            sleep_ff <= 1'b1;
        end
    end

    // Fast oscillator enable, gated off in sleep.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            fast_cnt_ff  <= 4'h0;
            o_sys_clk_en <= 1'b0;
        end else if (fast_cnt_ff == 4'(FAST_DIV - 1)) begin
            fast_cnt_ff  <= 4'h0;
            o_sys_clk_en <= !sleep_ff;
        end else begin
            fast_cnt_ff  <= fast_cnt_ff + 4'h1;
            o_sys_clk_en <= 1'b0;
        end
    end

    // Slow oscillator runs unless asleep with every user disabled.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            slow_run_ff <= 1'b1;
        end else begin
            slow_run_ff <= !(sleep_ff && !i_slow_users_on);
        end
    end

    // Slow enable divider for watchdog, timer, pulse width and time base.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            slow_cnt_ff   <= 14'h0000;
            o_slow_clk_en <= 1'b0;
        end else if (!slow_run_ff) begin
            o_slow_clk_en <= 1'b0;
        end else if (slow_cnt_ff == 14'(SLOW_DIV - 1)) begin
            slow_cnt_ff   <= 14'h0000;
            o_slow_clk_en <= 1'b1;
        end else begin
            slow_cnt_ff   <= slow_cnt_ff + 14'h0001;
            o_slow_clk_en <= 1'b0;
        end
    end

    // Sleep state shown to the core.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_sleeping <= 1'b0;
        end else begin
            o_sleeping <= sleep_ff;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_pc_page;
        @(posedge i_sys_clk) disable iff (i_reset)
        (bus_wr && wr_reg_ff == scr_pkg::SCR_REG_PC && pc_state_ff == scr_pkg::SCR_PC_RUN)
        |=> (o_pc_load[10:8] == $past(i_pc[10:8]) && o_pc_load[7:0] == $past(wbyte));
    endproperty
    a_pc_page: assert property (p_pc_page) else $error("PC page changed");

    property p_dummy;
        @(posedge i_sys_clk) disable iff (i_reset)
        $rose(o_pc_load_stb) |-> o_core_stall ##1 !o_core_stall;
    endproperty
    a_dummy: assert property (p_dummy) else $error("Dummy cycle wrong");

    property p_sys_keep;
        @(posedge i_sys_clk) disable iff (i_reset)
        (!i_sys_ev.wdt_timeout && !i_sys_ev.wdt_clear && !i_sys_ev.sleep)
        |=> $stable(status_ff[5:4]);
    endproperty
    a_sys_keep: assert property (p_sys_keep) else $error("System flag moved");

    property p_wdt_set;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_sys_ev.wdt_timeout |=> status_ff[`SCR_ST_WDT_EXP];
    endproperty
    a_wdt_set: assert property (p_wdt_set) else $error("Watchdog flag not set");

    property p_sleep_set;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_sys_ev.sleep && !i_sys_ev.wdt_timeout && !i_wake)
        |=> status_ff[`SCR_ST_SLEEP] && !status_ff[`SCR_ST_WDT_EXP] ##1 o_sleeping;
    endproperty
    a_sleep_set: assert property (p_sleep_set) else $error("Sleep entry wrong");

    property p_null;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_alu.valid && i_alu.upd_null) |=> status_ff[`SCR_ST_NULL] == ($past(i_alu.result) == 8'h00);
    endproperty
    a_null: assert property (p_null) else $error("Null flag wrong");

    property p_edge;
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 (o_ext_edge_sel == $past(ctrl_b_ff[7:6]));
    endproperty
    a_edge: assert property (p_edge) else $error("Edge select wrong");

    property p_slow_sleep;
        @(posedge i_sys_clk) disable iff (i_reset)
        (sleep_ff && i_slow_users_on) |=> slow_run_ff;
    endproperty
    a_slow_sleep: assert property (p_slow_sleep) else $error("Slow osc stopped");

    property p_zero_bits;
        @(posedge i_sys_clk) disable iff (i_reset)
        (ctrl_a_ff & ~`SCR_CTRL_A_MASK) == 8'h00 && (ctrl_b_ff & ~`SCR_CTRL_B_MASK) == 8'h00;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("Reserved bit set");

endmodule // scr_regs

//--- scr_map.svh
// Register offsets, field positions, reset values and timing counts of the
// status and system control register bank.
// Assumes a single 100 MHz clock and 32-bit AHB-Lite word addressing.
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCR_OFF_PC_LOW      12'h000
`define SCR_OFF_STATUS      12'h004
`define SCR_OFF_CTRL_A      12'h008
`define SCR_OFF_CTRL_B      12'h00C
`define SCR_OFF_OSC         12'h010

// ****************************************************************
// Field positions
// ****************************************************************
`define SCR_ST_WDT_EXP      5
`define SCR_ST_SLEEP        4
`define SCR_ST_WRAP         3
`define SCR_ST_NULL         2
`define SCR_ST_HALF         1
`define SCR_ST_CARRY        0
`define SCR_CA_SPLIT        5
`define SCR_CA_PWM_PIN      3
`define SCR_CA_PFD_PIN      2
`define SCR_STATUS_WMASK    8'h0F
`define SCR_CTRL_A_MASK     8'h2C
`define SCR_CTRL_B_MASK     8'hF0

// ****************************************************************
// Reset values
// ****************************************************************
`define SCR_CTRL_A_RST      8'h00
`define SCR_CTRL_B_RST      8'h80

// ****************************************************************
// Timing
// ****************************************************************
`define SCR_SYS_CLK_MHZ     100
`define SCR_FAST_OSC_MHZ    8
`define SCR_SLOW_OSC_HZ     12000
`define SCR_FAST_DIV        ((`SCR_SYS_CLK_MHZ + `SCR_FAST_OSC_MHZ - 1) / `SCR_FAST_OSC_MHZ)
`define SCR_SLOW_DIV        ((`SCR_SYS_CLK_MHZ * 1000000) / `SCR_SLOW_OSC_HZ)
`define SCR_TB_BASE_LOG2    10

`endif

//--- scr_pkg.sv
// Types shared by the status and system control register bank.
// Assumes scr_map.svh supplies all numeric constants.
package scr_pkg;

    // Flag update from the execution unit.
    typedef struct packed {
        logic       valid;
        logic       upd_wrap;
        logic       upd_null;
        logic       upd_half;
        logic       upd_carry;
        logic       is_sub;
        logic       is_rotate;
        logic       rot_carry;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [7:0] result;
    } scr_alu_type;

    // System events from the core.
    typedef struct packed {
        logic       wdt_timeout;
        logic       wdt_clear;
        logic       sleep;
    } scr_sys_ev_type;

    // Bus access decode.
    typedef enum logic [2:0] {
        SCR_REG_NONE,
        SCR_REG_PC,
        SCR_REG_STATUS,
        SCR_REG_CTRL_A,
        SCR_REG_CTRL_B,
        SCR_REG_OSC
    } scr_reg_type;

    // Program counter jump sequencing.
    typedef enum logic [1:0] {
        SCR_PC_RUN,
        SCR_PC_DUMMY
    } scr_pc_state_type;

endpackage

//--- scr_core_model.sv
// Behavioural model of the core that faces the register bank's core side.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/10ps
module scr_core_model (
    // Clock.
    input  wire logic                    i_sys_clk,
    // Jump request from the bank.
    input  wire logic [10:0]             i_pc_load,
    input  wire logic                    i_pc_load_stb,
    // Core outputs.
    output scr_pkg::scr_alu_type         o_alu,
    output scr_pkg::scr_sys_ev_type      o_sys_ev,
    output logic                         o_wake,
    output logic                         o_slow_users_on,
    output logic      [10:0]             o_pc
);
    // Strobes idle low; the program counter starts in page 3.
    initial begin
        o_alu = '0;
        o_sys_ev = '0;
        o_wake = 1'b0;
        o_slow_users_on = 1'b1;
        o_pc = 11'h3C1;
    end

    // Sends one-cycle strobes, so the bank never sees a held event.
    task automatic pulse(input scr_pkg::scr_alu_type a, input logic [2:0] e, input logic w);
        o_alu <= a;
        o_sys_ev <= e;
        o_wake <= w;
        @(posedge i_sys_clk);
        o_alu <= '0;
        o_sys_ev <= '0;
        o_wake <= 1'b0;
    endtask

    // Sets whether any slow-clock user is enabled.
    task automatic users(input logic on);
        o_slow_users_on <= on;
    endtask

    // The core follows a jump, so the page bits carry into the next one.
    always @(posedge i_sys_clk) begin
        if (i_pc_load_stb === 1'b1) begin
            o_pc <= i_pc_load;
        end
    end
endmodule // scr_core_model

//--- scr_regs_test.sv
// Self-checking bench of the register bank over its AHB-Lite port.
// Assumes the core model drives the core side of the bank.
`timescale 1ns/10ps
`include "scr_map.svh"
module scr_regs_test;
    logic        clk, rst, hsel, hwrite, hrdy, hresp, stb, stall, split, pin, programmable_freq_divider;
    logic        sysen, slowen, sleeping;
    logic [1:0]  htrans, edge_sel, tb_sel;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata;
    logic [10:0] pc, pc_load;
    logic [13:0] tb_cyc;
    logic [1:0]  e;
    logic        wake, users_on;
    int          errors, total_checks, c;
    scr_pkg::scr_alu_type    alu_v;
    scr_pkg::scr_sys_ev_type ev_v;

    scr_regs i_scr_regs (.i_sys_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_alu(alu_v), .i_sys_ev(ev_v), .i_wake(wake), .i_slow_users_on(users_on),
        .i_pc(pc), .o_pc_load(pc_load), .o_pc_load_stb(stb), .o_core_stall(stall),
        .o_pwm_split_7p1(split), .o_pwm_pin_sel(pin), .o_pfd_pin_sel(programmable_freq_divider),
        .o_ext_edge_sel(edge_sel), .o_tb_period_sel(tb_sel), .o_tb_period_cycles(tb_cyc),
        .o_sys_clk_en(sysen), .o_slow_clk_en(slowen), .o_sleeping(sleeping));
    scr_core_model i_scr_core_model (.i_sys_clk(clk), .i_pc_load(pc_load),
        .i_pc_load_stb(stb), .o_alu(alu_v), .o_sys_ev(ev_v), .o_wake(wake),
        .o_slow_users_on(users_on), .o_pc(pc));

    // Makes the 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for ready at a rising edge, with a bound.
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1) begin
            errors++;
            wrap_up;
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        wait_rdy;
        q = hrdata[7:0];
        chk({hresp, hrdata[31:8]}, 25'h0);
    endtask

    // Writes one register.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask

    // Reads one register and compares it.
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask

    // Counts clock-enable pulses over n cycles.
    task automatic cnt(input logic slow, input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge clk);
            k += ((slow ? slowen : sysen) === 1'b1);
        end
    endtask

    // Builds a flag update; a rotate touches only the carry.
    function automatic scr_pkg::scr_alu_type alu(input logic s, r, cy, input logic [7:0] a,
                                                  b, y);
        alu = {1'b1, {3{~r}}, 1'b1, s, r, cy, a, b, y};
    endfunction

    // Main sequence.
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 48'h0};
        errors = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({edge_sel, tb_cyc, split, pin, programmable_freq_divider, sleeping}, {2'b10, 14'd1024, 4'h0});
        rd(`SCR_OFF_STATUS, 8'h00);
        rd(`SCR_OFF_CTRL_A, 8'h00);
        rd(`SCR_OFF_CTRL_B, 8'h80);
        wr(`SCR_OFF_STATUS, 8'hFF);
        rd(`SCR_OFF_STATUS, 8'h0F);
        i_scr_core_model.pulse('0, 3'b100, 1'b0);
        rd(`SCR_OFF_STATUS, 8'h2F);
        wr(`SCR_OFF_STATUS, 8'h00);
        rd(`SCR_OFF_STATUS, 8'h20);
        i_scr_core_model.pulse('0, 3'b001, 1'b0);
        rd(`SCR_OFF_STATUS, 8'h10);
        chk(sleeping, 1);
        rd(`SCR_OFF_OSC, 8'h03);
        cnt(1'b0, 130, c);
        chk(c, 0);
        cnt(1'b1, 9000, c);
        chk(c != 0, 1);
        i_scr_core_model.users(1'b0);
        repeat (2) @(posedge clk);
        rd(`SCR_OFF_OSC, 8'h01);
        cnt(1'b1, 9000, c);
        chk(c, 0);
        i_scr_core_model.pulse('0, 3'b000, 1'b1);
        i_scr_core_model.users(1'b1);
        repeat (20) @(posedge clk);
        cnt(1'b0, 130, c);
        chk(c, 10);
        cnt(1'b1, 9000, c);
        chk(c != 0, 1);
        i_scr_core_model.pulse('0, 3'b010, 1'b0);
        rd(`SCR_OFF_STATUS, 8'h00);
        i_scr_core_model.pulse(alu(0, 0, 0, 8'h7F, 8'h01, 8'h80), 3'b000, 1'b0);
        rd(`SCR_OFF_STATUS, 8'h0A);
        i_scr_core_model.pulse(alu(0, 0, 0, 8'hFF, 8'h01, 8'h00), 3'b000, 1'b0);
        rd(`SCR_OFF_STATUS, 8'h07);
        i_scr_core_model.pulse(alu(1, 0, 0, 8'h10, 8'h01, 8'h0F), 3'b000, 1'b0);
        rd(`SCR_OFF_STATUS, 8'h01);
        i_scr_core_model.pulse(alu(0, 1, 0, 8'hFF, 8'h01, 8'h00), 3'b000, 1'b0);
        rd(`SCR_OFF_STATUS, 8'h00);
        wr(`SCR_OFF_CTRL_A, 8'hFF);
        rd(`SCR_OFF_CTRL_A, 8'h2C);
        chk({split, pin, programmable_freq_divider}, 3'b111);
        wr(`SCR_OFF_CTRL_A, 8'h20);
        rd(`SCR_OFF_CTRL_A, 8'h20);
        chk({split, pin, programmable_freq_divider}, 3'b100);
        for (int k = 0; k < 4; k++) begin
            e = k[1:0];
            wr(`SCR_OFF_CTRL_B, {e, ~e, 4'hF});
            rd(`SCR_OFF_CTRL_B, {e, ~e, 4'h0});
            chk({edge_sel, tb_sel}, {e, ~e});
            chk(tb_cyc, 14'd1024 << (~e));
        end
        rd(12'h020, 8'h00);
        wr(`SCR_OFF_PC_LOW, 8'h5A);
        c = 0;
        while (stb !== 1'b1 && c < 4) begin
            @(posedge clk);
            c++;
        end
        chk({stb, stall, pc_load}, {2'b11, 11'h35A});
        @(posedge clk);
        chk({stb, stall}, 2'b00);
        rd(`SCR_OFF_PC_LOW, 8'h5A);
        wrap_up;
    end
endmodule // scr_regs_test
